// >>> dual_dac_consts.svh
`ifndef DUAL_DAC_CONSTS_SVH
`define DUAL_DAC_CONSTS_SVH

// serial word layout
`define WORD_BITS      16
`define CNT_W          5
`define SEL_HI_POS     15
`define SPEED_POS      14
`define PDOWN_POS      13
`define SEL_LO_POS     12
`define DATA_MSB_POS   11
`define DATA_LSB_POS   4
`define CODE_MSB_POS   11
`define PAD_MSB_POS    3
`define SHIFT_MSB_POS  14

// output code width and padding
`define CODE_BITS      12
`define PAD_ZERO       4'h0

// register-select codes {high, low}
`define SEL_B_AND_BUF  2'h0
`define SEL_BUF_ONLY   2'h1
`define SEL_A_COPY_B   2'h2
`define SEL_RESERVED   2'h3

// power-on values and bit counter constants
`define RST_CODE       12'h000
`define RST_WORD       16'h0000
`define RST_CNT        5'h00
`define CNT_ONE        5'h01
`define CNT_FULL       5'h10
`define CNT_LAST       5'h0f

`endif

// >>> dual_dac_pkg.sv
package dual_dac_pkg;

    // framing of one serial word
    typedef enum {
        FR_IDLE,
        FR_SHIFT,
        FR_HELD
    } frame_e;

    // register-select pair {high, low}
    typedef logic [1:0] sel_t;

endpackage : dual_dac_pkg

// >>> dual_dac_serial_loader.sv
`include "dual_dac_consts.svh"

// How it works
// RULE1: power-on reset clears channel, buffer and control latches to zero.
// RULE2: after select falls, bits shift in on serial clock falling edges, MSB first.
// RULE3: after sixteen bits or select rising, the word moves to the chosen latches.
// RULE4: word is four program bits, eight data bits MSB first, four zeros.
// RULE5: bit 14 picks settling speed: 0 slow, 1 fast.
// RULE6: bit 13 set powers down regardless of other bits; clear means normal.
// RULE7: speed and power-down both start at zero after power-up.
// RULE8: select 00 loads channel B latch and the buffer latch.
// RULE9: select 01 loads only the buffer; channel latches untouched.
// RULE10: select 10 loads channel A and copies the buffer into channel B.
// RULE11: select 11 is reserved and changes no latch; the code still loads the speed and power-down bits.
// RULE12: twelve-bit output code spans 0x000 to 0xff0, low four bits zero.
// RULE13: host drops select with a falling edge before clocking a word.
// RULE14: byte-wide hosts send two bytes with select held low throughout.
// RULE15: latches update automatically on the sixteenth rising serial clock edge.
// RULE16: host keeps serial clock at or below 20 MHz.
// RULE17: buffered update changes both channels together after channel A word.
module dual_dac_serial_loader
    import dual_dac_pkg::*;
#(
    parameter int DATA_BITS = 8
) (
    // system clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst_n,
    // serial pins from the host
    input  wire logic                  sclk,
    input  wire logic                  cs_n,
    input  wire logic                  din,
    // channel codes toward the converters
    output logic [`CODE_BITS-1:0]      dac_a_code_q,
    output logic [`CODE_BITS-1:0]      dac_b_code_q,
    output logic [`CODE_BITS-1:0]      buffer_code_q,
    // control latch
    output logic                       fast_mode_q,
    output logic                       power_down_q,
    // one-cycle pulse after each latch transfer
    output logic                       word_done_q
);

    // the word layout is fixed at eight data bits plus four program and four pad bits
    if (DATA_BITS != `DATA_MSB_POS - `DATA_LSB_POS + 1) begin : g_bad_width
        $error("dual_dac_serial_loader: DATA_BITS must be 8");
    end

    logic              sclk_s1_q, sclk_s2_q, sclk_s3_q;
    logic              cs_s1_q, cs_s2_q;
    logic              din_s1_q, din_s2_q, din_s3_q;
    logic              sclk_fall, sclk_rise, cs_low;
    frame_e            frame_q;
    logic [`CNT_W-1:0] bit_cnt_q;
    logic [`WORD_BITS-1:0] shift_q;
    logic              commit_full, commit_early, commit;
    logic              register_select_high, register_select_low;
    logic              speed_select_bit, power_down_bit;
    sel_t              sel;
    logic [`CODE_BITS-1:0] new_code;

    // two flip-flops on every pin; a third stage on sclk finds edges and on din holds the sample taken before them
    // clock stages reset to the parked-high level so release shows no false edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sclk_s1_q <= 1'b1;
            sclk_s2_q <= 1'b1;
            sclk_s3_q <= 1'b1;
            cs_s1_q   <= 1'b1;
            cs_s2_q   <= 1'b1;
            din_s1_q  <= 1'b0;
            din_s2_q  <= 1'b0;
            din_s3_q  <= 1'b0;
        end else begin
            sclk_s1_q <= sclk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
            cs_s1_q   <= cs_n;
            cs_s2_q   <= cs_s1_q;
            din_s1_q  <= din;
            din_s2_q  <= din_s1_q;
            din_s3_q  <= din_s2_q;
        end
    end

    // din is taken one sample before the falling edge is seen, because the host
    // only holds data 5 ns past the edge, less than one system clock
    assign sclk_fall = sclk_s3_q & ~sclk_s2_q;
    assign sclk_rise = ~sclk_s3_q & sclk_s2_q;
    assign cs_low    = ~cs_s2_q;

    // framing: a word opens when select falls and is done once it is committed
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            frame_q <= FR_IDLE;
        end else begin
            unique case (frame_q)
                FR_IDLE: begin
                    if (cs_low) begin // RULE13
                        frame_q <= FR_SHIFT;
                    end
                end
                FR_SHIFT: begin
                    if (!cs_low) begin
                        frame_q <= FR_IDLE;
                    end else if (commit_full) begin
                        frame_q <= FR_HELD;
                    end
                end
                FR_HELD: begin
                    if (!cs_low) begin
                        frame_q <= FR_IDLE;
                    end
                end
            endcase
        end
    end

    // bit counter; extra clocks after the sixteenth bit are ignored
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            bit_cnt_q <= `RST_CNT;
        end else if (frame_q != FR_SHIFT) begin
            bit_cnt_q <= `RST_CNT;
        end else if (sclk_fall && bit_cnt_q != `CNT_FULL) begin
            bit_cnt_q <= bit_cnt_q + `CNT_ONE;
        end
    end

    // shift register, most significant bit arrives first
    // shifting stops at sixteen so trailing clocks cannot push program bits out
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            shift_q <= `RST_WORD; // RULE1
        end else if (frame_q == FR_SHIFT && cs_low && sclk_fall
                     && bit_cnt_q != `CNT_FULL) begin
            shift_q <= {shift_q[`SHIFT_MSB_POS:0], din_s3_q}; // RULE2
        end
    end

    // transfer on the sixteenth rising edge, or early when select rises mid-word
    assign commit_full  = frame_q == FR_SHIFT && cs_low && sclk_rise
                          && bit_cnt_q == `CNT_FULL; // RULE15
    assign commit_early = frame_q == FR_SHIFT && !cs_low && bit_cnt_q != `RST_CNT;
    assign commit       = commit_full || commit_early; // RULE3

    // program field decode
    assign register_select_high = shift_q[`SEL_HI_POS]; // RULE4
    assign speed_select_bit     = shift_q[`SPEED_POS];
    assign power_down_bit       = shift_q[`PDOWN_POS];
    assign register_select_low  = shift_q[`SEL_LO_POS];
    assign sel                  = {register_select_high, register_select_low};
    assign new_code = {shift_q[`DATA_MSB_POS:`DATA_LSB_POS], `PAD_ZERO}; // RULE12

    // control latch: power-down overrides everything else in the word
    // speed is kept across a power-down word; the word that wakes the part loads its own speed bit
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fast_mode_q  <= 1'b0; // RULE7
            power_down_q <= 1'b0; // RULE7
        end else if (commit) begin
            if (power_down_bit) begin
                power_down_q <= 1'b1; // RULE6
            end else begin
                power_down_q <= 1'b0; // RULE6
                fast_mode_q  <= speed_select_bit; // RULE5
            end
        end
    end

    // channel and buffer latches; pad bits are forced zero, not taken from the wire
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dac_a_code_q  <= `RST_CODE; // RULE1
            dac_b_code_q  <= `RST_CODE; // RULE1
            buffer_code_q <= `RST_CODE; // RULE1
        end else if (commit && !power_down_bit) begin
            unique case (sel)
                `SEL_B_AND_BUF: begin
                    dac_b_code_q  <= new_code; // RULE8
                    buffer_code_q <= new_code; // RULE8
                end
                `SEL_BUF_ONLY: begin
                    buffer_code_q <= new_code; // RULE9
                end
                `SEL_A_COPY_B: begin
                    dac_a_code_q <= new_code; // RULE10
                    dac_b_code_q <= buffer_code_q; // RULE17
                end
                `SEL_RESERVED: begin
                    dac_a_code_q <= dac_a_code_q; // RULE11
                end
            endcase
        end
    end

    // transfer pulse lets the analog side know the codes just moved
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            word_done_q <= 1'b0;
        end else begin
            word_done_q <= commit;
        end
    end

    // checks on the serial front end and the latches
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_word_full;
        frame_q == FR_SHIFT && cs_low && sclk_rise && bit_cnt_q == `CNT_FULL;
    endsequence

    sequence s_done_pulse;
        word_done_q ##1 !word_done_q;
    endsequence

    sequence s_take_bit;
        frame_q == FR_SHIFT && cs_low && sclk_fall && bit_cnt_q != `CNT_FULL;
    endsequence

    a_reset_clears: assert property (@(posedge sys_clk) disable iff (1'b0) // RULE1
        !rst_n |=> dac_a_code_q == `RST_CODE && dac_b_code_q == `RST_CODE
                   && buffer_code_q == `RST_CODE && !fast_mode_q && !power_down_q)
        else $error("latches not cleared by reset");

    a_shift_msb: assert property (s_take_bit |=> // RULE2
        shift_q[0] == $past(din_s3_q) && bit_cnt_q == $past(bit_cnt_q) + `CNT_ONE)
        else $error("serial bit not shifted in");

    a_full_commit: assert property (s_word_full |=> s_done_pulse) // RULE15
        else $error("no transfer on sixteenth rising edge");

    a_early_commit: assert property ( // RULE3
        frame_q == FR_SHIFT && cs_s2_q && bit_cnt_q != `RST_CNT |=> word_done_q)
        else $error("no transfer when select rose");

    a_no_stray: assert property (!commit |=> !word_done_q // RULE3
        && $stable(dac_a_code_q) && $stable(dac_b_code_q) && $stable(buffer_code_q))
        else $error("latch changed without a transfer");

    a_speed_set: assert property (commit && !power_down_bit |=> // RULE5
        fast_mode_q == $past(speed_select_bit) && !power_down_q)
        else $error("speed bit not latched");

    a_power_down: assert property (commit && power_down_bit |=> // RULE6
        power_down_q && $stable(fast_mode_q) && $stable(dac_a_code_q)
        && $stable(dac_b_code_q) && $stable(buffer_code_q))
        else $error("power-down word disturbed other latches");

    a_sel_b_buf: assert property (commit && !power_down_bit && sel == `SEL_B_AND_BUF |=> // RULE8
        dac_b_code_q == $past(new_code) && buffer_code_q == $past(new_code)
        && $stable(dac_a_code_q))
        else $error("select 00 load wrong");

    a_sel_buf: assert property (commit && !power_down_bit && sel == `SEL_BUF_ONLY |=> // RULE9
        buffer_code_q == $past(new_code) && $stable(dac_a_code_q) && $stable(dac_b_code_q))
        else $error("select 01 load wrong");

    a_sel_a_copy: assert property (commit && !power_down_bit && sel == `SEL_A_COPY_B |=> // RULE10
        dac_a_code_q == $past(new_code) && dac_b_code_q == $past(buffer_code_q))
        else $error("select 10 load wrong");

    a_reserved_hold: assert property (commit && sel == `SEL_RESERVED |=> // RULE11
        $stable(dac_a_code_q) && $stable(dac_b_code_q) && $stable(buffer_code_q))
        else $error("reserved select changed a latch");

    a_pad_zero: assert property (dac_a_code_q[`PAD_MSB_POS:0] == `PAD_ZERO // RULE12
        && dac_b_code_q[`PAD_MSB_POS:0] == `PAD_ZERO
        && buffer_code_q[`PAD_MSB_POS:0] == `PAD_ZERO)
        else $error("low code bits not zero");

    a_held_ignores: assert property (frame_q == FR_HELD && cs_low |=> // RULE3
        $stable(shift_q) && !word_done_q)
        else $error("bits taken after word complete");

    // a saturating counter keeps a long burst from wrapping into a second word
    a_cnt_bound: assert property (bit_cnt_q <= `CNT_FULL) // RULE3
        else $error("bit counter passed sixteen");

    // a frame must open as soon as select is seen low
    a_frame_open: assert property (frame_q == FR_IDLE && cs_low |=> // RULE2
        frame_q == FR_SHIFT)
        else $error("frame did not open on select low");

    // nothing is shifted or moved while the host has the part deselected
    a_idle_quiet: assert property (frame_q == FR_IDLE |=> // RULE13
        $stable(shift_q) && !word_done_q)
        else $error("bits taken while deselected");

    // after the sixteenth bit the frame parks until select rises
    a_full_held: assert property (s_word_full |=> frame_q == FR_HELD) // RULE15
        else $error("frame not held after sixteenth bit");

    // one word gives exactly one transfer pulse
    a_pulse_once: assert property (word_done_q |=> !word_done_q) // RULE3
        else $error("transfer pulse longer than one cycle");

    // both channels move in the cycle of the pulse, never one ahead of the other
    a_both_update: assert property (commit && !power_down_bit && sel == `SEL_A_COPY_B // RULE17
        |=> word_done_q && dac_a_code_q == $past(new_code)
            && dac_b_code_q == $past(buffer_code_q))
        else $error("channels did not update together");

endmodule : dual_dac_serial_loader

// >>> host_serial_model.sv
module host_serial_model (
    // serial pins toward the device
    output logic sclk,
    output logic cs_n,
    output logic din
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle: deselected, clock parked high
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // one frame, 125 ns per bit; split pauses mid-word like a byte-wide port
    task automatic send(input logic [15:0] w, input int nbits, input bit split);
        cs_n = 1'b0;
        #40;
        for (int i = 0; i < nbits; i++) begin
            if (split && i == 8) #300;
            din = (i < 16) ? w[15-i] : 1'b1;
            #30;
            sclk = 1'b0;
            #62.5;
            sclk = 1'b1;
            #32.5;
        end
        #40;
        cs_n = 1'b1;
        // released line must not keep showing the last bit
        din = ~din;
    endtask : send
endmodule : host_serial_model

// >>> dual_dac_serial_loader_bench.sv
`include "dual_dac_consts.svh"

module dual_dac_serial_loader_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic                  sys_clk = 1'b0;
    logic                  rst_n   = 1'b0;
    wire                   sclk;
    wire                   cs_n;
    wire                   din;
    logic [`CODE_BITS-1:0] dac_a_code_q;
    logic [`CODE_BITS-1:0] dac_b_code_q;
    logic [`CODE_BITS-1:0] buffer_code_q;
    logic                  fast_mode_q;
    logic                  power_down_q;
    logic                  word_done_q;
    logic [11:0]           e_a, e_b, e_buf;
    logic                  e_fast, e_pd;
    logic [31:0]           rng = 32'h0000dfc1;
    logic [15:0]           w;
    logic [15:0]           dir [6] = '{16'h1a50, 16'h8c30, 16'h4ff0, 16'h9770,
                                       16'h2000, 16'h0010};
    int                    n_mismatch, checked, n_done, exp_done, cycles;

    always #4 sys_clk = ~sys_clk;

    dual_dac_serial_loader dual_dac_serial_loader_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dac_a_code_q(dac_a_code_q), .dac_b_code_q(dac_b_code_q),
        .buffer_code_q(buffer_code_q), .fast_mode_q(fast_mode_q),
        .power_down_q(power_down_q), .word_done_q(word_done_q));

    host_serial_model host_serial_model_inst (.sclk(sclk), .cs_n(cs_n), .din(din));

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xorshift

    // expected latch state after one complete word
    function automatic void predict(input logic [15:0] x);
        logic [11:0] code;
        code = {x[11:4], 4'h0};
        if (x[13]) begin
            e_pd = 1'b1;
            return;
        end
        e_pd   = 1'b0;
        e_fast = x[14];
        case ({x[15], x[12]})
            2'h0: begin e_b = code; e_buf = code; end
            2'h1: e_buf = code;
            2'h2: begin e_a = code; e_b = e_buf; end
            default: ;
        endcase
    endfunction : predict

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic check_state();
        check({26'h0, dac_a_code_q, dac_b_code_q, buffer_code_q, fast_mode_q,
               power_down_q}, {26'h0, e_a, e_b, e_buf, e_fast, e_pd});
    endtask : check_state

    task wrap_up;
        $display("mismatches %0d, checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    // one frame, then the pulse count and, for whole words, the latches
    task automatic do_word(input logic [15:0] x, input int nbits, input bit split);
        host_serial_model_inst.send(x, nbits, split);
        if (nbits >= 16)
            predict(x);
        if (nbits > 0)
            exp_done++;
        repeat (10) @(negedge sys_clk);
        check(64'(n_done), 64'(exp_done));
        if (nbits >= 16) begin
            check({63'h0, fast_mode_q}, {63'h0, e_fast});
            check({63'h0, power_down_q}, {63'h0, e_pd});
            check({48'h0, dac_a_code_q[3:0], buffer_code_q}, {48'h0, 4'h0, e_buf});
            check_state();
        end
    endtask : do_word

    // pulse counter; the cycle ceiling cuts a hang short
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (word_done_q === 1'b1)
            n_done <= n_done + 1;
        if (cycles >= 30000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        {e_a, e_b, e_buf, e_fast, e_pd} = '0;
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check_state();
        foreach (dir[i])
            do_word(dir[i], 16, i[0]);
        do_word(16'h8550, 17, 1'b0);
        do_word(16'h1230, 0, 1'b0);
        for (int k = 0; k < 30; k++) begin
            rng = xorshift(rng);
            w = {rng[15:12], rng[11:4], 4'h0};
            // power-down words are kept rare so data paths see most traffic
            if (rng[23:20] != 4'h0)
                w[13] = 1'b0;
            do_word(w, 16, rng[24]);
        end
        // partial word commits on select rising; contents unchecked
        do_word(16'hc350, 9, 1'b0);
        rst_n = 1'b0;
        repeat (4) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        {e_a, e_b, e_buf, e_fast, e_pd} = '0;
        check_state();
        do_word(16'h1f00, 16, 1'b1);
        wrap_up();
    end
endmodule : dual_dac_serial_loader_bench
